/* pkg/umcs_pkg.sv */
// Package with offsets, fields, reset values and carriers of the modem block.
package umcs_pkg;

    // Register offsets on the 3-bit register port.
    localparam logic [2:0] OFS_DIV_LO = 3'h0;
    localparam logic [2:0] OFS_DIV_HI = 3'h1;
    localparam logic [2:0] OFS_INT_EN = 3'h1;
    localparam logic [2:0] OFS_LINE_CTL = 3'h3;
    localparam logic [2:0] OFS_MDM_CTL = 3'h4;
    localparam logic [2:0] OFS_MDM_STS = 3'h6;

    // Modem control field positions.
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_GOA = 2;
    localparam int MC_GOB = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_W = 5;

    // Modem status field positions.
    localparam int MS_CTS_CHG = 0;
    localparam int MS_DSR_CHG = 1;
    localparam int MS_RI_TRAIL = 2;
    localparam int MS_DCD_CHG = 3;

    // Line control and interrupt enable field positions.
    localparam int LC_DIV_ACC = 7;
    localparam int IE_MODEM = 3;
    localparam int IE_W = 4;

    // Reset values.
    localparam logic [4:0] MC_RST = 5'h00;
    localparam logic [3:0] IE_RST = 4'h0;
    localparam logic LC_ACC_RST = 1'b0;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [4:0] SYNC_RST = 5'h1F;

    // Modem input states in status bit order, bit 7 downward.
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } umcs_mdm_t;

endpackage

/* rtl/umcs_baud_gen.sv */
// Reloadable down counter that makes the 16x baud tick.
`timescale 1ns/10ps
module umcs_baud_gen
#(
    parameter int DIV_W = 16
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [DIV_W-1:0] divisor_i,
    input wire logic reload_i,
    output logic tick_o
);

    logic [DIV_W-1:0] count_ff;
    logic tick_ff;
    logic at_end;

    // A single wide counter cannot serve widths below two bits.
    if (DIV_W < 2)
    begin
        $error("umcs_baud_gen: DIV_W must be at least 2.");
    end

    // A zero divisor is not legal, so the counter simply parks.
    assign at_end = (count_ff <= {{(DIV_W-1){1'b0}}, 1'b1});

    ////////////////////////////////////////////////////////////////////////
    // A write to the divisor reloads at once so a long count never lingers.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            count_ff <= '0;
        else if (reload_i)
            count_ff <= divisor_i; // R19
        else if (divisor_i == '0)
            count_ff <= '0;
        else if (at_end)
            count_ff <= divisor_i; // R22
        else
            count_ff <= count_ff - {{(DIV_W-1){1'b0}}, 1'b1}; // R17
    end

    // One tick per terminal count gives one tick every divisor cycles.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            tick_ff <= 1'b0;
        else
            tick_ff <= !reload_i && (divisor_i != '0) && at_end; // R22
    end

    assign tick_o = tick_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks of reload and terminal count.
    property p_reload;
        @(posedge core_clk_i) disable iff (reset_i)
        reload_i |=> (count_ff == $past(divisor_i)) && !tick_o;
    endproperty
    a_reload: assert property (p_reload) // R19
        else $error("Divisor write did not reload the counter.");

    property p_term;
        @(posedge core_clk_i) disable iff (reset_i)
        (count_ff == 1) && !reload_i && (divisor_i != '0)
            |=> tick_o && (count_ff == $past(divisor_i));
    endproperty
    a_term: assert property (p_term) // R22
        else $error("Terminal count did not tick and reload.");

    property p_no_tick;
        @(posedge core_clk_i) disable iff (reset_i)
        (count_ff > 1) |=> !tick_o;
    endproperty
    a_no_tick: assert property (p_no_tick) // R17
        else $error("Tick seen before terminal count.");

endmodule

/* rtl/umcs_top.sv */
// Modem control, modem status and baud divisor logic of a serial controller.
//
// Operation
// R1: Modem control bits 0-3 drive DTR, RTS, outputs A and B low when set.
// R2: Modem control bits 5-7 always read back as zero.
// R3: Loopback bit 4 forces serial output to mark and ignores serial input.
// R4: In loopback the transmit shift output feeds the receive shift input.
// R5: In loopback modem input pins are ignored; control bits replace them.
// R6: In loopback all four modem output pins sit high, inactive.
// R7: Loopback status shows RTS as CTS, DTR as DSR, A as RI, B as DCD.
// R8: Loopback modem interrupt uses control bits, still gated by enable.
// R9: Status bits 4-7 are the inverted CTS, DSR, RI, DCD pins, live.
// R10: CTS, DSR and DCD change flags set on any level change.
// R11: Ring flag sets only when the RI pin goes low to high.
// R12: Reading modem status clears the change flags, not the live bits.
// R13: Interrupt enable bit 3 raises the interrupt on any modem change.
// R14: Change during read: set flag ignores it, clear flag records after.
// R15: Status flags cannot set during a status read; set after it ends.
// R16: Flag already set and recurring during read is cleared at read end.
// R17: Baud generator divides the clock by divisor 1-65535 for 16x rate.
// R18: Divisor is 16 bits across a low byte and a high byte latch.
// R19: Writing either divisor byte reloads the baud counter at once.
// R20: Software programs both divisor bytes before serial transfers.
// R21: Divisor access bit 7 selects divisor bytes at shared offsets.
// R22: Counter counts down, ticks at terminal count and reloads divisor.
`timescale 1ns/10ps
module umcs_top
#(
    parameter int DIV_W = 16
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic ri_n_i,
    input wire logic dcd_n_i,
    output logic dtr_n_o,
    output logic rts_n_o,
    output logic general_output_a_n_o,
    output logic general_output_b_n_o,
    input wire logic serial_in_i,
    input wire logic tx_shift_i,
    output logic serial_out_o,
    output logic rx_shift_o,
    output logic divisor_access_bit_o,
    output logic baud_tick_o,
    output logic interrupt_out_o
);

    // The divisor is exactly two byte latches wide.
    if (DIV_W != 16)
    begin
        $error("umcs_top: DIV_W must be 16.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [umcs_pkg::MC_W-1:0] modem_control_reg_ff;
    logic [umcs_pkg::IE_W-1:0] interrupt_enable_reg_ff;
    logic divisor_access_bit_ff;
    logic [DIV_W-1:0] divisor_ff;
    logic baud_reload_ff;
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] sync3_ff;
    logic [4:0] pin_filt_ff;
    umcs_pkg::umcs_mdm_t live;
    umcs_pkg::umcs_mdm_t live_ff;
    logic [3:0] change_ev;
    logic [3:0] chg_flags_ff;
    logic [3:0] pend_ff;
    logic [7:0] rdata_ff;
    logic dtr_n_ff;
    logic rts_n_ff;
    logic goa_n_ff;
    logic gob_n_ff;
    logic serial_out_ff;
    logic rx_shift_ff;
    logic int_ff;
    logic loop_on;
    logic sel_div_lo;
    logic sel_div_hi;
    logic sel_int_en;
    logic sel_line_ctl;
    logic sel_mdm_ctl;
    logic sel_mdm_sts;
    logic sts_rd;

    // Matches an offset and the divisor access state it needs.
    function automatic logic umcs_hit(input logic [2:0] addr,
                                      input logic [2:0] ofs,
                                      input logic acc_need,
                                      input logic acc_now,
                                      input logic acc_care);
        umcs_hit = (addr == ofs) && (!acc_care || (acc_now == acc_need));
    endfunction

    assign loop_on = modem_control_reg_ff[umcs_pkg::MC_LOOP];

    ////////////////////////////////////////////////////////////////////////
    // Address decode; the shared offsets depend on the access bit.
    always_comb
    begin
        sel_div_lo = 1'b0;
        sel_div_hi = 1'b0;
        sel_int_en = 1'b0;
        sel_line_ctl = 1'b0;
        sel_mdm_ctl = 1'b0;
        sel_mdm_sts = 1'b0;
        if (umcs_hit(reg_addr_i, umcs_pkg::OFS_DIV_LO, 1'b1,
                     divisor_access_bit_ff, 1'b1))
            sel_div_lo = 1'b1; // R21
        else if (umcs_hit(reg_addr_i, umcs_pkg::OFS_DIV_HI, 1'b1,
                          divisor_access_bit_ff, 1'b1))
            sel_div_hi = 1'b1; // R21
        else if (umcs_hit(reg_addr_i, umcs_pkg::OFS_INT_EN, 1'b0,
                          divisor_access_bit_ff, 1'b1))
            sel_int_en = 1'b1; // R21
        else if (umcs_hit(reg_addr_i, umcs_pkg::OFS_LINE_CTL, 1'b0,
                          divisor_access_bit_ff, 1'b0))
            sel_line_ctl = 1'b1;
        else if (umcs_hit(reg_addr_i, umcs_pkg::OFS_MDM_CTL, 1'b0,
                          divisor_access_bit_ff, 1'b0))
            sel_mdm_ctl = 1'b1;
        else if (umcs_hit(reg_addr_i, umcs_pkg::OFS_MDM_STS, 1'b0,
                          divisor_access_bit_ff, 1'b0))
            sel_mdm_sts = 1'b1;
    end

    assign sts_rd = reg_rd_i && sel_mdm_sts;

    ////////////////////////////////////////////////////////////////////////
    // Modem control; only five bits exist, so bits 5-7 cannot hold a one.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            modem_control_reg_ff <= umcs_pkg::MC_RST;
        else if (reg_wr_i && sel_mdm_ctl)
            modem_control_reg_ff <= reg_wdata_i[umcs_pkg::MC_W-1:0]; // R2
    end

    // Access bit and interrupt enable bits.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            divisor_access_bit_ff <= umcs_pkg::LC_ACC_RST;
            interrupt_enable_reg_ff <= umcs_pkg::IE_RST;
        end
        else
        begin
            if (reg_wr_i && sel_line_ctl)
                divisor_access_bit_ff <= reg_wdata_i[umcs_pkg::LC_DIV_ACC];
            if (reg_wr_i && sel_int_en)
                interrupt_enable_reg_ff <= reg_wdata_i[umcs_pkg::IE_W-1:0];
        end
    end

    // Divisor byte latches; either write also reloads the counter.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            divisor_ff <= umcs_pkg::DIV_RST;
            baud_reload_ff <= 1'b0;
        end
        else
        begin
            if (reg_wr_i && sel_div_lo)
                divisor_ff[7:0] <= reg_wdata_i; // R18
            if (reg_wr_i && sel_div_hi)
                divisor_ff[15:8] <= reg_wdata_i; // R18
            baud_reload_ff <= reg_wr_i && (sel_div_lo || sel_div_hi); // R19
        end
    end

    // The counter sees the new divisor in the same cycle as the reload.
    umcs_baud_gen #(
        .DIV_W(DIV_W)
    ) u_baud_generator (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .divisor_i(divisor_ff),
        .reload_i(baud_reload_ff),
        .tick_o(baud_tick_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs pass three stages; a bit changes once stages two and
    // three agree, which also rejects a single-cycle glitch.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            sync1_ff <= umcs_pkg::SYNC_RST;
            sync2_ff <= umcs_pkg::SYNC_RST;
            sync3_ff <= umcs_pkg::SYNC_RST;
            pin_filt_ff <= umcs_pkg::SYNC_RST;
        end
        else
        begin
            sync1_ff <= {serial_in_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < 5; i++)
                if (sync2_ff[i] == sync3_ff[i])
                    pin_filt_ff[i] <= sync3_ff[i];
        end
    end

    // Live status: inverted pins, or the control bits in loopback.
    always_comb
    begin
        if (loop_on)
        begin
            live.cts = modem_control_reg_ff[umcs_pkg::MC_RTS]; // R7
            live.dsr = modem_control_reg_ff[umcs_pkg::MC_DTR]; // R7
            live.ri = modem_control_reg_ff[umcs_pkg::MC_GOA]; // R7
            live.dcd = modem_control_reg_ff[umcs_pkg::MC_GOB]; // R5
        end
        else
        begin
            live = ~umcs_pkg::umcs_mdm_t'(pin_filt_ff[3:0]); // R9
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            live_ff <= '0;
        else
            live_ff <= live; // R9
    end

    // Change events; ring counts only status 1 to 0, the pin's rise.
    always_comb
    begin
        change_ev[umcs_pkg::MS_CTS_CHG] = live.cts ^ live_ff.cts; // R10
        change_ev[umcs_pkg::MS_DSR_CHG] = live.dsr ^ live_ff.dsr; // R10
        change_ev[umcs_pkg::MS_RI_TRAIL] = live_ff.ri & ~live.ri; // R11
        change_ev[umcs_pkg::MS_DCD_CHG] = live.dcd ^ live_ff.dcd; // R10
    end

    ////////////////////////////////////////////////////////////////////////
    // Change flags. Setting is held off during the read cycle; a change
    // on a clear flag lands one cycle later, a change on a set flag is
    // dropped and the flag still clears.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            chg_flags_ff <= 4'h0;
        else if (sts_rd)
            chg_flags_ff <= 4'h0; // R12 R15 R16
        else
            chg_flags_ff <= chg_flags_ff | change_ev | pend_ff; // R10
    end

    // A pending change survives back-to-back reads, so it is never lost.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            pend_ff <= 4'h0;
        else if (sts_rd)
            pend_ff <= pend_ff | (change_ev & ~chg_flags_ff); // R14
        else
            pend_ff <= 4'h0;
    end

    // Modem interrupt request, gated by its enable in every mode.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            int_ff <= 1'b0;
        else
            int_ff <= interrupt_enable_reg_ff[umcs_pkg::IE_MODEM]
                      && (chg_flags_ff != 4'h0); // R13 R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins leave from flops; loopback parks outputs inactive and marking.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            dtr_n_ff <= 1'b1;
            rts_n_ff <= 1'b1;
            goa_n_ff <= 1'b1;
            gob_n_ff <= 1'b1;
        end
        else
        begin
            dtr_n_ff <= loop_on
                        || !modem_control_reg_ff[umcs_pkg::MC_DTR]; // R1 R6
            rts_n_ff <= loop_on
                        || !modem_control_reg_ff[umcs_pkg::MC_RTS]; // R1 R6
            goa_n_ff <= loop_on
                        || !modem_control_reg_ff[umcs_pkg::MC_GOA]; // R1 R6
            gob_n_ff <= loop_on
                        || !modem_control_reg_ff[umcs_pkg::MC_GOB]; // R1 R6
        end
    end

    // Serial path: in loopback transmit data goes straight to receive.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            serial_out_ff <= 1'b1;
            rx_shift_ff <= 1'b1;
        end
        else
        begin
            serial_out_ff <= loop_on || tx_shift_i; // R3
            rx_shift_ff <= loop_on ? tx_shift_i : pin_filt_ff[4]; // R3 R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stand for one cycle only; unmapped offsets read zero.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            rdata_ff <= 8'h00;
        else if (!reg_rd_i)
            rdata_ff <= 8'h00;
        else if (sel_div_lo)
            rdata_ff <= divisor_ff[7:0];
        else if (sel_div_hi)
            rdata_ff <= divisor_ff[15:8];
        else if (sel_int_en)
            rdata_ff <= {4'h0, interrupt_enable_reg_ff};
        else if (sel_line_ctl)
            rdata_ff <= {divisor_access_bit_ff, 7'h00};
        else if (sel_mdm_ctl)
            rdata_ff <= {3'h0, modem_control_reg_ff}; // R2
        else if (sel_mdm_sts)
            rdata_ff <= {live_ff, chg_flags_ff}; // R9
        else
            rdata_ff <= 8'h00;
    end

    assign reg_rdata_o = rdata_ff;
    assign dtr_n_o = dtr_n_ff;
    assign rts_n_o = rts_n_ff;
    assign general_output_a_n_o = goa_n_ff;
    assign general_output_b_n_o = gob_n_ff;
    assign serial_out_o = serial_out_ff;
    assign rx_shift_o = rx_shift_ff;
    assign divisor_access_bit_o = divisor_access_bit_ff;
    assign interrupt_out_o = int_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_mc_write;
        reg_wr_i && sel_mdm_ctl && !reg_wdata_i[umcs_pkg::MC_LOOP];
    endsequence

    property p_mc_pins;
        @(posedge core_clk_i) disable iff (reset_i)
        s_mc_write |=> ##1 (dtr_n_o == !$past(reg_wdata_i[0], 2))
            && (general_output_b_n_o == !$past(reg_wdata_i[3], 2));
    endproperty
    a_mc_pins: assert property (p_mc_pins) // R1
        else $error("Control write did not reach the pins.");

    property p_mc_zero;
        @(posedge core_clk_i) disable iff (reset_i)
        reg_rd_i && sel_mdm_ctl |=> (reg_rdata_o[7:5] == 3'h0);
    endproperty
    a_mc_zero: assert property (p_mc_zero) // R2
        else $error("Control bits 5-7 read as nonzero.");

    property p_loop_out;
        @(posedge core_clk_i) disable iff (reset_i)
        loop_on |=> serial_out_o && (rx_shift_o == $past(tx_shift_i))
            && dtr_n_o && rts_n_o && general_output_a_n_o
            && general_output_b_n_o;
    endproperty
    a_loop_out: assert property (p_loop_out) // R3 R4 R6
        else $error("Loopback outputs wrong.");

    property p_loop_sts;
        @(posedge core_clk_i) disable iff (reset_i)
        loop_on |=> (live_ff.cts == $past(modem_control_reg_ff[1]))
            && (live_ff.dsr == $past(modem_control_reg_ff[0]))
            && (live_ff.ri == $past(modem_control_reg_ff[2]))
            && (live_ff.dcd == $past(modem_control_reg_ff[3]));
    endproperty
    a_loop_sts: assert property (p_loop_sts) // R7
        else $error("Loopback status mapping wrong.");

    property p_pin_sts;
        @(posedge core_clk_i) disable iff (reset_i)
        !loop_on |=> (live_ff == ~$past(pin_filt_ff[3:0]));
    endproperty
    a_pin_sts: assert property (p_pin_sts) // R9
        else $error("Status does not follow inverted pins.");

    property p_rd_clear;
        @(posedge core_clk_i) disable iff (reset_i)
        sts_rd |=> (chg_flags_ff == 4'h0) && (live_ff == $past(live));
    endproperty
    a_rd_clear: assert property (p_rd_clear) // R12
        else $error("Status read did not clear change flags.");

    sequence s_rd_new_change;
        sts_rd && !chg_flags_ff[0] && change_ev[0];
    endsequence

    property p_rd_late;
        @(posedge core_clk_i) disable iff (reset_i)
        s_rd_new_change ##1 !sts_rd |=> chg_flags_ff[0];
    endproperty
    a_rd_late: assert property (p_rd_late) // R14 R15
        else $error("Change during read was lost.");

    property p_ring_edge;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(chg_flags_ff[2]) |-> $past(change_ev[2] || pend_ff[2]);
    endproperty
    a_ring_edge: assert property (p_ring_edge) // R11
        else $error("Ring flag set without a trailing edge.");

    property p_irq;
        @(posedge core_clk_i) disable iff (reset_i)
        ##1 (interrupt_out_o == $past(interrupt_enable_reg_ff[3]
            && (chg_flags_ff != 4'h0)));
    endproperty
    a_irq: assert property (p_irq) // R13
        else $error("Modem interrupt does not match flags and enable.");

endmodule

/* tb/umcs_modem_model.sv */
// Modem model that drives the four modem status pins with a selectable lag.
`timescale 1ns/10ps
module umcs_modem_model
(
    input wire logic core_clk_i,
    input wire logic [3:0] want_i,
    input wire logic [3:0] lag_i,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic ri_n_o,
    output logic dcd_n_o
);
    // Pins power up inactive, so the block sees no change on reset release.
    logic [3:0] pins_ff = 4'hF;
    logic [3:0] cnt_ff = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // A new wanted level reaches the pins only after lag_i cycles.
    always_ff @(posedge core_clk_i)
    begin
        if ((~want_i != pins_ff) && (cnt_ff < lag_i))
            cnt_ff <= cnt_ff + 4'h1;
        else
        begin
            pins_ff <= ~want_i;
            cnt_ff <= 4'h0;
        end
    end

    // Wanted states are active high; the pins are active low.
    assign {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = pins_ff;
endmodule

/* tb/testbench.sv */
// Self-checking testbench of the modem control, status and baud block.
`timescale 1ns/10ps
module testbench;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic serial_in_i = 1'b0;
    logic tx_shift_i = 1'b1;
    logic [3:0] want = 4'h0;
    logic [3:0] lag = 4'h0;
    logic cts_n, dsr_n, ri_n, dcd_n;
    logic [7:0] reg_rdata_o;
    logic dtr_n_o, rts_n_o, goa_n, gob_n, serial_out_o, rx_shift_o;
    logic divisor_access_bit_o, baud_tick_o, interrupt_out_o;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic [7:0] v;
    logic [3:0] lv;
    logic b;
    logic [15:0] divs[3] = '{16'h0003, 16'h0102, 16'h0001};
    integer seed = 32'hDDA2;
    int fails = 0;
    int samples_checked = 0;
    int n;

    umcs_top #(.DIV_W(16)) dut_u (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
        .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
        .general_output_a_n_o(goa_n), .general_output_b_n_o(gob_n),
        .serial_in_i(serial_in_i), .tx_shift_i(tx_shift_i),
        .serial_out_o(serial_out_o), .rx_shift_o(rx_shift_o),
        .divisor_access_bit_o(divisor_access_bit_o),
        .baud_tick_o(baud_tick_o), .interrupt_out_o(interrupt_out_o));

    umcs_modem_model modem_u (.core_clk_i(core_clk_i), .want_i(want),
        .lag_i(lag), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
        .dcd_n_o(dcd_n));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // Compares one result and counts it.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle register read; the expected byte waits in the queue.
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
    endtask

    // Measures the spacing of two ticks, bounded so a dead counter ends.
    task automatic measure(input logic [15:0] d);
        int k;
        k = 0;
        while (baud_tick_o !== 1'b1 && k < 1000)
        begin
            @(posedge core_clk_i);
            k++;
        end
        k = 0;
        do
        begin
            @(posedge core_clk_i);
            k++;
        end
        while (baud_tick_o !== 1'b1 && k < 1000);
        chk(16'(k), d);
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    always @(posedge core_clk_i)
    begin
        rd_d <= reg_rd_i;
        if (rd_d)
            chk(reg_rdata_o, exp_q.pop_front());
    end

    // Watchdog sized well above the longest sequence.
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        chk({gob_n, goa_n, rts_n_o, dtr_n_o, serial_out_o}, 5'h1F);
        rd(3'h6, 8'h00);
        rd(3'h0, 8'h00);
        $display("Test reset done");
        repeat (6)
        begin
            v = 8'($random(seed));
            v[4] = 1'b0;
            wr(3'h4, v);
            rd(3'h4, v & 8'h1F);
            @(posedge core_clk_i);
            chk({gob_n, goa_n, rts_n_o, dtr_n_o}, {~v[3:0]});
        end
        $display("Test modem control done");
        v = 8'($random(seed));
        wr(3'h4, v | 8'hF0);
        repeat (10) @(posedge core_clk_i);
        chk({gob_n, goa_n, rts_n_o, dtr_n_o}, 4'hF);
        rd(3'h4, (v & 8'h0F) | 8'h10);
        lv = {v[3], v[2], v[0], v[1]};
        rd(3'h6, {lv, v[3], 1'b0, v[0], v[1]});
        want <= 4'hF;
        repeat (10) @(posedge core_clk_i);
        rd(3'h6, {lv, 4'h0});
        repeat (8)
        begin
            b = 1'($random(seed));
            @(posedge core_clk_i);
            tx_shift_i <= b;
            serial_in_i <= ~b;
            repeat (2) @(posedge core_clk_i);
            chk({rx_shift_o, serial_out_o}, {b, 1'b1});
        end
        wr(3'h4, 8'h00);
        repeat (10) @(posedge core_clk_i);
        rd(3'h6, {4'hF, ~v[3], 1'b0, ~v[0], ~v[1]});
        chk({rx_shift_o, serial_out_o}, {~b, b});
        $display("Test loopback done");
        lag <= 4'h3;
        wr(3'h1, 8'h08);
        want <= 4'hB;
        repeat (12) @(posedge core_clk_i);
        chk(interrupt_out_o, 1'b1);
        rd(3'h6, 8'hB4);
        repeat (3) @(posedge core_clk_i);
        chk(interrupt_out_o, 1'b0);
        want <= 4'hF;
        repeat (12) @(posedge core_clk_i);
        chk(interrupt_out_o, 1'b0);
        rd(3'h6, 8'hF0);
        wr(3'h1, 8'h00);
        want <= 4'hE;
        repeat (12) @(posedge core_clk_i);
        chk(interrupt_out_o, 1'b0);
        rd(3'h6, 8'hE1);
        // Changes timed to land in the status read cycle itself.
        want <= 4'hF;
        repeat (12) @(posedge core_clk_i);
        want <= 4'hE;
        repeat (7) @(posedge core_clk_i);
        rd(3'h6, 8'hF1);
        rd(3'h6, 8'hE0);
        want <= 4'hF;
        repeat (7) @(posedge core_clk_i);
        rd(3'h6, 8'hE0);
        rd(3'h6, 8'hF1);
        $display("Test status flags done");
        wr(3'h3, 8'h80);
        rd(3'h3, 8'h80);
        chk(divisor_access_bit_o, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            wr(3'h0, divs[i][7:0]);
            wr(3'h1, divs[i][15:8]);
            rd(3'h0, divs[i][7:0]);
            rd(3'h1, divs[i][15:8]);
            measure(divs[i]);
        end
        wr(3'h1, 8'h01);
        repeat (100) @(posedge core_clk_i);
        wr(3'h1, 8'h00);
        n = 0;
        while (baud_tick_o !== 1'b1 && n < 300)
        begin
            @(posedge core_clk_i);
            n++;
        end
        chk(n <= 5, 1'b1);
        $display("Test baud generator done");
        repeat (4) @(posedge core_clk_i);
        report_and_stop();
    end
endmodule
